// ===== core/atb_pkg.sv
// Constants and carrier types of the task-file PIO bridge
package atb_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Task-file slot offsets in the host register map
    localparam logic [7:0] ATB_OFS_DATA     = 8'h40;   // 16-bit data word
    localparam logic [7:0] ATB_OFS_COMMAND  = 8'h44;   // Command, write only
    localparam logic [7:0] ATB_OFS_ERRFEAT  = 8'h48;   // Error / feature
    localparam logic [7:0] ATB_OFS_SECCNT   = 8'h49;   // Sector count
    localparam logic [7:0] ATB_OFS_SECNUM   = 8'h4A;   // Sector number
    localparam logic [7:0] ATB_OFS_CYLLO    = 8'h4B;   // Cylinder low
    localparam logic [7:0] ATB_OFS_CYLHI    = 8'h4C;   // Cylinder high
    localparam logic [7:0] ATB_OFS_DRVHEAD  = 8'h4D;   // Drive / head
    localparam logic [7:0] ATB_OFS_ALTSTAT  = 8'h4E;   // Alt status / control
    localparam logic [7:0] ATB_OFS_DRVADDR  = 8'h4F;   // Drive address

    ////////////////////////////////////////////////////////////////////////
    // Slot indices into the holding memory
    localparam logic [3:0] ATB_IDX_DATA     = 4'h0;
    localparam logic [3:0] ATB_IDX_FIRST_TF = 4'h1;    // First slot read back
    localparam logic [3:0] ATB_IDX_LAST_TF  = 4'h6;    // Last slot read back
    localparam logic [3:0] ATB_IDX_COMMAND  = 4'h7;
    localparam logic [3:0] ATB_IDX_ALTSTAT  = 4'h8;
    localparam logic [3:0] ATB_IDX_DRVADDR  = 4'h9;
    localparam int         ATB_SLOTS        = 10;

    ////////////////////////////////////////////////////////////////////////
    // Values and reset values
    localparam logic [7:0]  ATB_READ_ONES   = 8'hFF;   // Command slot read value
    localparam logic [7:0]  ATB_BYTE_RESET  = 8'h00;
    localparam logic [15:0] ATB_WORD_RESET  = 16'h0000;

    ////////////////////////////////////////////////////////////////////////
    // PIO cycle timing
    localparam int ATB_CLK_NS     = 20;
    localparam int ATB_SETUP_NS   = 40;
    localparam int ATB_STROBE_NS  = 100;
    localparam int ATB_HOLD_NS    = 20;
    localparam logic [3:0] ATB_SETUP_CYC  =
        4'((ATB_SETUP_NS + ATB_CLK_NS - 1) / ATB_CLK_NS);
    localparam logic [3:0] ATB_STROBE_CYC =
        4'((ATB_STROBE_NS + ATB_CLK_NS - 1) / ATB_CLK_NS);
    localparam logic [3:0] ATB_HOLD_CYC   =
        4'((ATB_HOLD_NS + ATB_CLK_NS - 1) / ATB_CLK_NS);

    ////////////////////////////////////////////////////////////////////////
    // Peripheral register select: chip selects and device address
    typedef struct packed {
        logic       cs1n;   // Control-block select, low active
        logic       cs0n;   // Command-block select, low active
        logic [2:0] da;     // Device address
    } atb_sel_type;

    localparam atb_sel_type ATB_SEL_IDLE = '{cs1n: 1'b1, cs0n: 1'b1, da: 3'h0};

    // Result of decoding a host offset
    typedef struct packed {
        logic        hit;   // Offset is a task-file slot
        logic [3:0]  idx;   // Slot index
        atb_sel_type sel;   // Peripheral select for the slot
    } atb_slot_type;

    // PIO engine states, Gray along the path
    typedef enum logic [1:0] {
        ATB_ST_IDLE   = 2'b00,
        ATB_ST_SETUP  = 2'b01,
        ATB_ST_STROBE = 2'b11,
        ATB_ST_HOLD   = 2'b10
    } atb_state_type;

endpackage

// ===== core/atb_slot_mem.sv
// Holding memory for the task-file slot values
`timescale 1ns/1ps
module atb_slot_mem
    import atb_pkg::*;
(
    // Clock and clear
    input  wire logic       mclk_i,
    input  wire logic       clr_i,
    // Write port
    input  wire logic       we_i,
    input  wire logic [3:0] waddr_i,
    input  wire logic [7:0] wdata_i,
    // Read port
    input  wire logic [3:0] raddr_i,
    output logic      [7:0] rdata_o
);

    // One byte per slot
    logic [7:0] mem [ATB_SLOTS];

    ////////////////////////////////////////////////////////////////////////
    // Each entry clears or takes a write
    genvar g;
    generate
        for (g = 0; g < ATB_SLOTS; g++) begin : g_slot
            always_ff @(posedge mclk_i) begin
                if (clr_i) begin
                    mem[g] <= ATB_BYTE_RESET;
                end else if (we_i && (waddr_i == 4'(g))) begin
                    mem[g] <= wdata_i;
                end
            end
        end
    endgenerate

    // Registered read data
    always_ff @(posedge mclk_i) begin
        if (clr_i) begin
            rdata_o <= ATB_BYTE_RESET;
        end else begin
            rdata_o <= (raddr_i < 4'(ATB_SLOTS)) ? mem[raddr_i] : ATB_BYTE_RESET;
        end
    end

endmodule

// ===== core/atb_bridge.sv
// Task-file PIO bridge between the host register port and the IDE side
//
// Notes on behaviour
// - Slots 40h, 44h and 48h-4Fh each run a peripheral PIO access
// - Bridge drives both selects and device address
// - Data 40h: cs1 high, cs0 low, 000
// - Error/feature 48h: cs1 high, cs0 low, 001
// - Sector count 49h: cs1 high, cs0 low, 010
// - Sector number 4Ah: cs1 high, cs0 low, 011
// - Cylinder low 4Bh: cs1 high, cs0 low, 100
// - Cylinder high 4Ch: cs1 high, cs0 low, 101
// - Drive/head 4Dh: cs1 high, cs0 low, 110
// - Command 44h: cs1 high, cs0 low, 111
// - Command slot write only, reads FFh
// - Alt status 4Eh: cs1 low, cs0 high, 110
// - Drive address 4Fh: cs1 low, cs0 high, 111
// - 8-bit host: PIO only after second data access
// - Byte pair order: low byte first, high second
// - Other slots: one access, one PIO cycle
// - Flag unread data word held for host
// - Flag task-file read sequence completed
`timescale 1ns/1ps
module atb_bridge
    import atb_pkg::*;
(
    // Clock and resets
    input  wire logic        mclk_i,
    input  wire logic        rstn_i,
    input  wire logic        bus_reset_i,
    // Host register port
    input  wire logic        host_req_i,
    input  wire logic        host_wr_i,
    input  wire logic [7:0]  host_addr_i,
    input  wire logic [15:0] host_wdata_i,
    input  wire logic        host_bus16_i,
    output logic             host_ack_o,
    output logic             host_busy_o,
    output logic      [15:0] host_rdata_o,
    // Status and task-file read control
    input  wire logic        tf_read_start_i,
    input  wire logic        unread_clr_i,
    input  wire logic        tf_done_clr_i,
    input  wire logic [3:0]  hold_idx_i,
    output logic      [7:0]  hold_data_o,
    output logic             data_fifo_unread_flag_o,
    output logic             taskfile_read_done_flag_o,
    // IDE interface
    output logic             control_block_select_n_o,
    output logic             command_block_select_n_o,
    output logic             device_addr_bit2_o,
    output logic             device_addr_bit1_shared_o,
    output logic             device_addr_bit0_shared_o,
    output logic             ide_rd_n_o,
    output logic             ide_wr_n_o,
    output logic      [15:0] ide_data_o,
    output logic             ide_data_oe_o,
    input  wire logic [15:0] ide_data_i
);

    ////////////////////////////////////////////////////////////////////////
    // Offset decode, used for host accesses and the read-back walk
    function automatic atb_slot_type slot_decode(input logic [7:0] ofs);
        atb_slot_type s;
        s = '{hit: 1'b1, idx: ATB_IDX_DATA, sel: '{1'b1, 1'b0, 3'h0}};
        unique case (ofs)
            ATB_OFS_DATA:    s.idx = ATB_IDX_DATA;
            ATB_OFS_ERRFEAT: begin s.idx = 4'h1; s.sel.da = 3'h1; end
            ATB_OFS_SECCNT:  begin s.idx = 4'h2; s.sel.da = 3'h2; end
            ATB_OFS_SECNUM:  begin s.idx = 4'h3; s.sel.da = 3'h3; end
            ATB_OFS_CYLLO:   begin s.idx = 4'h4; s.sel.da = 3'h4; end
            ATB_OFS_CYLHI:   begin s.idx = 4'h5; s.sel.da = 3'h5; end
            ATB_OFS_DRVHEAD: begin s.idx = 4'h6; s.sel.da = 3'h6; end
            ATB_OFS_COMMAND: begin
                s.idx = ATB_IDX_COMMAND;
                s.sel.da = 3'h7;
            end
            ATB_OFS_ALTSTAT: begin
                s.idx = ATB_IDX_ALTSTAT;
                s.sel = '{1'b0, 1'b1, 3'h6};
            end
            ATB_OFS_DRVADDR: begin
                s.idx = ATB_IDX_DRVADDR;
                s.sel = '{1'b0, 1'b1, 3'h7};
            end
            default:         s.hit = 1'b0;                               // Unmapped
        endcase
        return s;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // State
    logic          clr;             // Either reset
    atb_state_type st;              // PIO engine state
    logic [3:0]    cnt;             // Phase cycle counter
    logic          pio_wr;          // Current PIO is a write
    logic          pio_word;        // Current PIO is the data word
    logic          pio_host;        // Current PIO answers the host
    logic [3:0]    pio_idx;         // Slot of the current PIO
    logic          pair_hi;         // Next 8-bit data access is high byte
    logic [7:0]    lsb_q;           // Low byte of a written pair
    logic [15:0]   word_q;          // Last word read from the data slot
    logic          tfr_active;      // Read-back walk running
    logic [3:0]    tfr_idx;         // Slot being read back

    assign clr = !rstn_i || bus_reset_i;

    ////////////////////////////////////////////////////////////////////////
    // Request classification
    atb_slot_type  hdec;            // Host offset decode
    atb_slot_type  tdec;            // Read-back slot decode
    logic          acc;             // Host request taken
    logic          acc_data;        // Taken on the data slot
    logic          acc_cmd_rd;      // Read of the command slot
    logic          acc_first;       // First byte of an 8-bit pair
    logic          acc_pio;         // Taken request starts a PIO
    logic          tfr_start;       // Read-back walk starts
    logic          tfr_pio;         // Read-back walk issues next PIO
    logic          pio_start;       // Engine leaves idle
    logic          pio_done;        // Last hold cycle
    logic          quick_ack;       // Answer without a PIO
    logic [7:0]    tfr_ofs;         // Offset of the read-back slot
    logic [15:0]   rd_word;         // Sampled peripheral data

    assign hdec       = slot_decode(host_addr_i);
    assign acc        = host_req_i && (st == ATB_ST_IDLE) && !tfr_active && !host_ack_o;
    assign acc_data   = acc && hdec.hit && (hdec.idx == ATB_IDX_DATA);
    assign acc_cmd_rd = acc && hdec.hit && !host_wr_i && (hdec.idx == ATB_IDX_COMMAND);
    assign acc_first  = acc_data && !host_bus16_i && !pair_hi;
    assign acc_pio    = acc && hdec.hit && !acc_cmd_rd && !acc_first;
    assign quick_ack  = acc && !acc_pio;
    assign tfr_start  = tf_read_start_i && !tfr_active && (st == ATB_ST_IDLE) && !acc;
    assign tfr_pio    = tfr_active && (st == ATB_ST_IDLE);
    assign pio_start  = acc_pio || tfr_pio;
    assign pio_done   = (st == ATB_ST_HOLD) && (cnt == ATB_HOLD_CYC - 4'h1);
    assign tfr_ofs    = ATB_OFS_ERRFEAT + {4'h0, tfr_idx} - 8'h01;
    assign tdec       = slot_decode(tfr_ofs);
    assign rd_word    = pio_word ? samp_q : {8'h00, samp_q[7:0]};

    ////////////////////////////////////////////////////////////////////////
    // PIO engine: setup, strobe, hold, each a fixed count
    logic          phase_end;       // Current phase finishes
    atb_state_type next_st;
    assign phase_end = ((st == ATB_ST_SETUP) && (cnt == ATB_SETUP_CYC - 4'h1))
                    || ((st == ATB_ST_STROBE) && (cnt == ATB_STROBE_CYC - 4'h1))
                    || pio_done;

    always_comb begin
        next_st = st;
        unique case (st)
            ATB_ST_IDLE:   if (pio_start) next_st = ATB_ST_SETUP;
            ATB_ST_SETUP:  if (phase_end) next_st = ATB_ST_STROBE;
            ATB_ST_STROBE: if (phase_end) next_st = ATB_ST_HOLD;
            ATB_ST_HOLD:   if (phase_end) next_st = ATB_ST_IDLE;
        endcase
    end

    // State and phase counter
    always_ff @(posedge mclk_i) begin
        if (clr) begin
            st  <= ATB_ST_IDLE;
            cnt <= 4'h0;
        end else begin
            st  <= next_st;
            cnt <= (phase_end || st == ATB_ST_IDLE) ? 4'h0 : cnt + 4'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Latch the PIO target and drive the selects for its whole length
    atb_sel_type sel_q;             // Current peripheral select
    always_ff @(posedge mclk_i) begin
        if (clr) begin
            sel_q    <= ATB_SEL_IDLE;
            pio_wr   <= 1'b0;
            pio_word <= 1'b0;
            pio_host <= 1'b0;
            pio_idx  <= ATB_IDX_DATA;
        end else if (pio_start) begin
            sel_q    <= acc_pio ? hdec.sel : tdec.sel;
            pio_wr   <= acc_pio && host_wr_i;
            pio_word <= acc_pio && (hdec.idx == ATB_IDX_DATA);
            pio_host <= acc_pio;
            pio_idx  <= acc_pio ? hdec.idx : tfr_idx;
        end else if (pio_done) begin
            sel_q    <= ATB_SEL_IDLE;
        end
    end

    assign control_block_select_n_o  = sel_q.cs1n;
    assign command_block_select_n_o  = sel_q.cs0n;
    assign device_addr_bit2_o        = sel_q.da[2];
    assign device_addr_bit1_shared_o = sel_q.da[1];
    assign device_addr_bit0_shared_o = sel_q.da[0];

    // Strobes, low active, only in the strobe phase
    always_ff @(posedge mclk_i) begin
        if (clr) begin
            ide_rd_n_o <= 1'b1;
            ide_wr_n_o <= 1'b1;
        end else begin
            ide_rd_n_o <= !(next_st == ATB_ST_STROBE && !pio_wr);
            ide_wr_n_o <= !(next_st == ATB_ST_STROBE && pio_wr);
        end
    end

    // Write data; a pair sends the held low byte under the new high byte
    always_ff @(posedge mclk_i) begin
        if (clr) begin
            ide_data_o    <= ATB_WORD_RESET;
            ide_data_oe_o <= 1'b0;
        end else begin
            if (acc_pio && host_wr_i) begin
                if (acc_data && !host_bus16_i) begin
                    ide_data_o <= {host_wdata_i[7:0], lsb_q};
                end else if (acc_data) begin
                    ide_data_o <= host_wdata_i;
                end else begin
                    ide_data_o <= {8'h00, host_wdata_i[7:0]};
                end
            end
            ide_data_oe_o <= (next_st != ATB_ST_IDLE) && (pio_start ? host_wr_i && acc_pio
                                                                     : pio_wr);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Byte pairing for an 8-bit host on the data slot
    always_ff @(posedge mclk_i) begin
        if (clr) begin
            pair_hi <= 1'b0;
            lsb_q   <= ATB_BYTE_RESET;
        end else if (acc_data && !host_bus16_i) begin
            pair_hi <= !pair_hi;
            if (acc_first && host_wr_i) begin
                lsb_q <= host_wdata_i[7:0];
            end
        end
    end

    // Word last read from the data register
    always_ff @(posedge mclk_i) begin
        if (clr) begin
            word_q <= ATB_WORD_RESET;
        end else if (pio_done && !pio_wr && pio_word) begin
            word_q <= rd_word;
        end
    end

    // Sample the peripheral at the end of the strobe
    logic [15:0] samp_q;            // Peripheral data captured
    always_ff @(posedge mclk_i) begin
        if (clr) begin
            samp_q <= ATB_WORD_RESET;
        end else if (st == ATB_ST_STROBE && phase_end && !pio_wr) begin
            samp_q <= ide_data_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Host answer: one cycle pulse with read data
    always_ff @(posedge mclk_i) begin
        if (clr) begin
            host_ack_o   <= 1'b0;
            host_rdata_o <= ATB_WORD_RESET;
        end else begin
            host_ack_o <= quick_ack || (pio_done && pio_host);
            if (acc_cmd_rd) begin
                host_rdata_o <= {8'h00, ATB_READ_ONES};
            end else if (acc_first) begin
                host_rdata_o <= {8'h00, word_q[7:0]};
            end else if (acc_data && !host_bus16_i) begin
                host_rdata_o <= {8'h00, word_q[15:8]};
            end else if (quick_ack) begin
                host_rdata_o <= ATB_WORD_RESET;
            end else if (pio_done && pio_host && !pio_wr && pio_word && host_bus16_i) begin
                host_rdata_o <= samp_q;
            end else if (pio_done && pio_host && !pio_wr && !pio_word) begin
                host_rdata_o <= {8'h00, samp_q[7:0]};
            end
        end
    end

    // Busy while a PIO or the read-back walk runs
    always_ff @(posedge mclk_i) begin
        if (clr) begin
            host_busy_o <= 1'b0;
        end else begin
            host_busy_o <= (next_st != ATB_ST_IDLE) || tfr_start
                        || (tfr_active && !(pio_done && tfr_idx == ATB_IDX_LAST_TF));
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read-back walk over slots one to six
    logic tfr_last;                 // Final read-back cycle done
    assign tfr_last = tfr_active && pio_done && !pio_host && (tfr_idx == ATB_IDX_LAST_TF);
    always_ff @(posedge mclk_i) begin
        if (clr) begin
            tfr_active <= 1'b0;
            tfr_idx    <= ATB_IDX_FIRST_TF;
        end else if (tfr_start) begin
            tfr_active <= 1'b1;
            tfr_idx    <= ATB_IDX_FIRST_TF;
        end else if (tfr_last) begin
            tfr_active <= 1'b0;
        end else if (tfr_active && pio_done) begin
            tfr_idx    <= tfr_idx + 4'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Status flags; a set in the clearing cycle wins
    logic unread_set;               // 8-bit refill of the data word done
    logic next_unread;
    logic next_tf_done;
    assign unread_set   = pio_done && !pio_wr && pio_word && !host_bus16_i;
    assign next_unread  = unread_set
                       || (data_fifo_unread_flag_o && !unread_clr_i && !acc_first);
    assign next_tf_done = tfr_last || (taskfile_read_done_flag_o && !tf_done_clr_i);

    always_ff @(posedge mclk_i) begin
        if (clr) begin
            data_fifo_unread_flag_o   <= 1'b0;
            taskfile_read_done_flag_o <= 1'b0;
        end else begin
            data_fifo_unread_flag_o   <= next_unread;
            taskfile_read_done_flag_o <= next_tf_done;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Holding memory: host writes and peripheral reads of the byte slots land here, not the data word
    logic       mem_we;
    logic [3:0] mem_waddr;
    logic [7:0] mem_wdata;
    assign mem_we    = (acc && host_wr_i && hdec.hit && !acc_data)
                    || (pio_done && !pio_wr && !pio_word);
    assign mem_waddr = acc ? hdec.idx : pio_idx;
    assign mem_wdata = acc ? host_wdata_i[7:0] : samp_q[7:0];

    atb_slot_mem u_mem (
        .mclk_i  (mclk_i),
        .clr_i   (clr),
        .we_i    (mem_we),
        .waddr_i (mem_waddr),
        .wdata_i (mem_wdata),
        .raddr_i (hold_idx_i),
        .rdata_o (hold_data_o)
    );

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (clr);

    cmd_read_ones_a: assert property (acc_cmd_rd |=> host_ack_o && host_rdata_o[7:0] == 8'hFF)
        else $error("command slot read did not return all ones");
    first_byte_nopio_a: assert property (acc_first |=> st == ATB_ST_IDLE && host_ack_o)
        else $error("first byte of pair started a PIO");
    pair_order_a: assert property (acc_pio && acc_data && host_wr_i && !host_bus16_i
        |=> ide_data_o == {$past(host_wdata_i[7:0]), $past(lsb_q)})
        else $error("byte pair assembled in wrong order");
    single_access_a: assert property (acc_pio && !acc_data |=> st == ATB_ST_SETUP)
        else $error("single access did not start a PIO");
    word_access_a: assert property (acc_data && host_bus16_i |=> st == ATB_ST_SETUP)
        else $error("16-bit data access did not start a PIO");
    data_select_a: assert property (st == ATB_ST_STROBE && pio_word
        |-> sel_q == atb_sel_type'{1'b1, 1'b0, 3'h0})
        else $error("data slot select wrong");
    alt_select_a: assert property (st == ATB_ST_STROBE && pio_idx == ATB_IDX_ALTSTAT
        |-> sel_q == atb_sel_type'{1'b0, 1'b1, 3'h6})
        else $error("alternate status select wrong");
    strobe_len_a: assert property ($fell(ide_rd_n_o) |-> !ide_rd_n_o [*5] ##1 ide_rd_n_o)
        else $error("read strobe length wrong");
    unread_set_a: assert property (unread_set |=> data_fifo_unread_flag_o)
        else $error("unread flag not set after refill");
    tf_done_a: assert property (tfr_last |=> taskfile_read_done_flag_o && !tfr_active)
        else $error("read-back done flag not set");
    pio_ack_a: assert property (acc_pio |-> ##9 host_ack_o)
        else $error("PIO access not answered in time");

endmodule

// ===== testbench/atb_disk_model.sv
// IDE peripheral model holding task-file registers
`timescale 1ns/1ps
module atb_disk_model (
    // IDE side of the bridge
    input  wire logic        cs1n_i,
    input  wire logic        cs0n_i,
    input  wire logic [2:0]  da_i,
    input  wire logic        rd_n_i,
    input  wire logic        wr_n_i,
    input  wire logic [15:0] wdata_i,
    output logic      [15:0] rdata_o,
    output int               wr_count_o
);
    logic [15:0] regs [16] = '{default: 16'h0000}; // Registers by {cs1n, da}
    logic [15:0] last = 16'h0000;                  // Last driven word
    initial wr_count_o = 0;
    // Latch a write at the trailing strobe edge, one select low
    always @(posedge wr_n_i) if ((cs1n_i ^ cs0n_i) === 1'b1) begin
        regs[{cs1n_i, da_i}] = wdata_i;
        wr_count_o++;
    end
    // Released bus shows the inverse of the last word
    always @(posedge rd_n_i) last = regs[{cs1n_i, da_i}];
    assign rdata_o = (rd_n_i === 1'b0) ? regs[{cs1n_i, da_i}] : ~last;
endmodule

// ===== testbench/atb_bridge_test.sv
// Bench for the task-file PIO bridge
`timescale 1ns/1ps
module atb_bridge_test;
    import atb_pkg::*;
    logic mclk_i, rstn_i, bus_reset_i, host_req_i, host_wr_i, host_bus16_i, host_ack_o;
    logic host_busy_o, tf_read_start_i, unread_clr_i, tf_done_clr_i, ide_rd_n_o, ide_wr_n_o;
    logic data_fifo_unread_flag_o, taskfile_read_done_flag_o, ide_data_oe_o;
    logic control_block_select_n_o, command_block_select_n_o, device_addr_bit2_o;
    logic device_addr_bit1_shared_o, device_addr_bit0_shared_o;
    logic [7:0] host_addr_i, hold_data_o, b;
    logic [3:0] hold_idx_i;
    logic [15:0] host_wdata_i, host_rdata_o, ide_data_o, ide_data_i, rd, w;
    logic [31:0] seed = 32'he94d_214b;
    int err_count = 0, checks_done = 0, wc;
    logic [7:0] ofs [10] = '{8'h40, 8'h48, 8'h49, 8'h4A, 8'h4B, 8'h4C, 8'h4D, 8'h44, 8'h4E, 8'h4F};
    int key [10] = '{8, 9, 10, 11, 12, 13, 14, 15, 6, 7}; // Expected {cs1n, da}
    logic [15:0] exp_q [10];                              // Values written
    atb_bridge i_atb_bridge (.mclk_i(mclk_i), .rstn_i(rstn_i), .bus_reset_i(bus_reset_i),
        .host_req_i(host_req_i), .host_wr_i(host_wr_i), .host_addr_i(host_addr_i),
        .host_wdata_i(host_wdata_i), .host_bus16_i(host_bus16_i), .host_ack_o(host_ack_o),
        .host_busy_o(host_busy_o), .host_rdata_o(host_rdata_o),
        .tf_read_start_i(tf_read_start_i), .unread_clr_i(unread_clr_i),
        .tf_done_clr_i(tf_done_clr_i), .hold_idx_i(hold_idx_i), .hold_data_o(hold_data_o),
        .data_fifo_unread_flag_o(data_fifo_unread_flag_o),
        .taskfile_read_done_flag_o(taskfile_read_done_flag_o),
        .control_block_select_n_o(control_block_select_n_o),
        .command_block_select_n_o(command_block_select_n_o),
        .device_addr_bit2_o(device_addr_bit2_o),
        .device_addr_bit1_shared_o(device_addr_bit1_shared_o),
        .device_addr_bit0_shared_o(device_addr_bit0_shared_o),
        .ide_rd_n_o(ide_rd_n_o), .ide_wr_n_o(ide_wr_n_o), .ide_data_o(ide_data_o),
        .ide_data_oe_o(ide_data_oe_o), .ide_data_i(ide_data_i));
    atb_disk_model i_atb_disk_model (.cs1n_i(control_block_select_n_o),
        .cs0n_i(command_block_select_n_o), .da_i({device_addr_bit2_o,
        device_addr_bit1_shared_o, device_addr_bit0_shared_o}), .rd_n_i(ide_rd_n_o),
        .wr_n_i(ide_wr_n_o), .wdata_i(ide_data_o), .rdata_o(ide_data_i), .wr_count_o(wc));
    initial begin
        mclk_i = 1'b0;
        forever #10 mclk_i = ~mclk_i;
    end
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
        checks_done++;
        if (g !== e) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", s, e, g);
        end
    endtask
    // One host access, wait bounded for the answer
    task automatic host(input logic wr, input logic [7:0] a, input logic [15:0] d);
        int n = 0;
        @(negedge mclk_i);
        {host_req_i, host_wr_i, host_addr_i, host_wdata_i} = {1'b1, wr, a, d};
        @(negedge mclk_i);
        host_req_i = 1'b0;
        while (host_ack_o !== 1'b1 && n < 30) begin
            @(negedge mclk_i);
            n++;
        end
        chk("ack", 1'b1, n < 30);
        rd = host_rdata_o;
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin
        #200us;
        err_count++;
        print_verdict();
    end
    initial begin
        {rstn_i, bus_reset_i, host_req_i, host_wr_i, host_bus16_i} = 5'b0_0001;
        {tf_read_start_i, unread_clr_i, tf_done_clr_i, hold_idx_i} = '0;
        {host_addr_i, host_wdata_i} = '0;
        repeat (12) @(negedge mclk_i);
        rstn_i = 1'b1;
        for (int n = 0; n < 10; n++) begin
            int j;
            j = (n == 9) ? 7 : ((n > 6) ? n + 1 : n);
            w = 16'(rnd());
            exp_q[j] = (j == 0) ? w : {8'h00, w[7:0]};
            host(1'b1, ofs[j], w);
            rd = i_atb_disk_model.regs[key[j]];
            chk("select", exp_q[j], (j == 0) ? rd : {8'h00, rd[7:0]});
            chk("pio count", n + 1, wc);
        end
        for (int j = 0; j < 10; j++) begin
            host(1'b0, ofs[j], 16'h0000);
            chk("read", (j == 7) ? 16'h00FF : exp_q[j], (j == 0) ? rd : {8'h00, rd[7:0]});
        end
        $display("test slots done");
        @(negedge mclk_i);
        {bus_reset_i, host_bus16_i} = 2'b10;
        @(negedge mclk_i);
        bus_reset_i = 1'b0;
        for (int k = 0; k < 4; k++) begin
            host(1'b0, ATB_OFS_DATA, 16'h0000);
            w = (k < 2) ? 16'h0000 : exp_q[0];
            chk("byte read", k[0] ? w[15:8] : w[7:0], {8'h00, rd[7:0]});
        end
        chk("unread", 1'b1, data_fifo_unread_flag_o);
        b = 8'(rnd());
        host(1'b1, ATB_OFS_DATA, {8'h00, b});
        chk("no pio first", 10, wc);
        host(1'b1, ATB_OFS_DATA, 16'h005A);
        chk("word", {8'h5A, b}, i_atb_disk_model.regs[8]);
        $display("test byte pairs done");
        @(negedge mclk_i);
        tf_read_start_i = 1'b1;
        @(negedge mclk_i);
        tf_read_start_i = 1'b0;
        chk("busy", 1'b1, host_busy_o);
        chk("oe", 1'b0, ide_data_oe_o);
        repeat (80) @(negedge mclk_i);
        chk("tf done", 1'b1, taskfile_read_done_flag_o);
        chk("idle", 1'b0, host_busy_o);
        for (int i = 1; i < 7; i++) begin
            hold_idx_i = 4'(i);
            @(negedge mclk_i);
            chk("hold", exp_q[i], {8'h00, hold_data_o});
        end
        {tf_done_clr_i, unread_clr_i} = 2'b11;
        @(negedge mclk_i);
        {tf_done_clr_i, unread_clr_i} = 2'b00;
        chk("tf clear", 1'b0, taskfile_read_done_flag_o);
        $display("test read-back done");
        print_verdict();
    end
endmodule
